// *** ofm_pkg.sv ***
// ================================================================
// shared constants and types
package ofm_pkg;
	localparam int OFM_CHANNELS = 16;
	localparam int OFM_ADDR_W = 8;

	// ================================================================
	// register offsets
	localparam logic [7:0] OFM_CTRL_OFS = 8'h00;
	localparam logic [7:0] OFM_STATUS_OFS = 8'h04;
	localparam logic [7:0] OFM_TARGET_OFS = 8'h08;
	localparam logic [7:0] OFM_FAILSAFE_OFS = 8'h0C;
	localparam logic [7:0] OFM_ERROR_OFS = 8'h10;
	localparam logic [7:0] OFM_LOCK_OFS = 8'h14;
	localparam logic [7:0] OFM_DRIVE_OFS = 8'h18;
	localparam logic [7:0] OFM_DELAY_OFS = 8'h40;

	// ================================================================
	// field positions
	localparam int OFM_CTRL_REPORT_BIT = 0;
	localparam int OFM_CTRL_PRIO_BIT = 1;
	localparam int OFM_STATUS_LINK_BIT = 0;
	localparam int OFM_STATUS_PRIOREJ_BIT = 1;
	localparam int OFM_DRIVE_ARMED_POS = 16;

	// ================================================================
	// reset values
	localparam logic OFM_REPORT_RST = 1'b1;
	localparam logic [15:0] OFM_TARGET_RST = 16'h0000;
	localparam logic [31:0] OFM_FAILSAFE_RST = 32'h0000_0000;
	localparam logic [7:0] OFM_DELAY_RST_MS = 8'h50;

	// ================================================================
	// timing
	localparam int OFM_CLK_PERIOD_NS = 100;
	localparam int OFM_MS_NS = 1000000;
	localparam int OFM_TICK_CYCLES = OFM_MS_NS / OFM_CLK_PERIOD_NS;
	localparam int OFM_STATIC_FILTER_MS = 100;
	localparam logic [6:0] OFM_STATIC_FILTER = 7'(OFM_STATIC_FILTER_MS);

	// ================================================================
	// fail-safe policy codes
	typedef enum logic [1:0] {
		OFM_FS_OFF = 2'h0,
		OFM_FS_ON = 2'h1,
		OFM_FS_HOLD = 2'h2,
		OFM_FS_RSVD = 2'h3
	} ofm_fs_t;

	// register bus request
	typedef struct packed {
		logic [OFM_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ofm_bus_req_t;
endpackage

// *** ofm_chan_mon.sv ***
`timescale 1ns/1ps
`default_nettype none
// ================================================================
// per-channel blanking timer and static mismatch filter
module ofm_chan_mon
	import ofm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// time base
	input wire logic msTick,
	// channel state
	input wire logic cmdOn,
	input wire logic actualOn,
	input wire logic [7:0] delayMs,
	// result
	output logic armed,
	output logic fault
);
	logic prevCmd_q;
	logic [7:0] blank_q;
	logic [6:0] filt_q;
	logic cmdEdge;
	logic mismatch;

	assign cmdEdge = cmdOn != prevCmd_q;
	assign mismatch = cmdOn != actualOn;
	assign armed = blank_q == 8'h00;
	assign fault = filt_q == OFM_STATIC_FILTER;

	// previous commanded state for edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prevCmd_q <= 1'b0;
		end else begin
			prevCmd_q <= cmdOn;
		end
	end

	// blanking restarts on either edge; reset starts suppressed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			blank_q <= OFM_DELAY_RST_MS;
		end else if (cmdEdge) begin
			blank_q <= delayMs;
		end else if (msTick && !armed) begin
			blank_q <= blank_q - 8'h01;
		end
	end

	// mismatch must persist a fixed window once armed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			filt_q <= 7'h00;
		end else if (cmdEdge || !armed || !mismatch) begin
			filt_q <= 7'h00;
		end else if (msTick && !fault) begin
			filt_q <= filt_q + 7'h01;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	no_fault_blank_a: assert property (!armed |-> !fault)
		else $error("fault while blanking");
	edge_reload_a: assert property (cmdEdge |=> blank_q == $past(delayMs))
		else $error("blanking not reloaded");
endmodule
`default_nettype wire

// *** ofm_output_ctrl.sv ***
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - when the controller link is lost every output goes to its configured fail-safe state; the code keeps a locked channel off instead.
// - the fail-safe code is 0 for off, 1 for on and 2 for keep the last commanded value.
// - each output channel has its own monitoring-delay setting.
// - a channel's delay timer restarts on every rising or falling edge of its commanded state.
// - error detection on a channel is suppressed until its delay has run out.
// - the delay accepts 0 to 255 ms and defaults to 80 ms.
// - a channel that stays on or off uses a fixed 100 ms error filter.
// - one global setting enables or disables diagnostic alarm reporting.
// - fail-safe and delay exist only on variants that have outputs.
// - prioritized startup is not supported and requests for it are refused.
// - a channel error is found by comparing commanded and measured output values.
// - a channel locked by an error is forced off until the controller resets it.
module ofm_output_ctrl
	import ofm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = OFM_TICK_CYCLES,
	parameter bit HAS_OUTPUTS = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire ofm_bus_req_t busReq,
	output logic [31:0] rdData,
	// link and field pins
	input wire logic linkUp,
	input wire logic [15:0] actualIn,
	output logic [15:0] outDrive,
	// diagnostics
	output logic [15:0] chanError,
	output logic diagAlarm
);
	// ================================================================
	// declarations
	logic [1:0] linkSync_q;
	logic [15:0] act1_q;
	logic [15:0] act2_q;
	logic report_q;
	logic prioRej_q;
	logic [15:0] target_q;
	logic [15:0] last_q;
	logic [31:0] failsafe_q;
	logic [7:0] delay_q [OFM_CHANNELS];
	logic [15:0] error_q;
	logic [15:0] lock_q;
	logic [15:0] drive_q;
	logic [31:0] rdData_q;
	logic [31:0] tick_q;
	logic msTick;
	logic linkOk;
	logic [15:0] cmd;
	logic [15:0] driveD;
	logic [15:0] armed;
	logic [15:0] fault;
	logic [15:0] faultPrev_q;
	logic [15:0] faultRise;
	logic [15:0] shortEvt;
	logic [15:0] lockSet;
	logic [15:0] errClr;
	logic [15:0] unlock;
	logic wrCtrl;
	logic wrStatus;
	logic delayHit;
	logic [3:0] delayIdx;

	// ================================================================
	// input synchronisers
	// pins are asynchronous to clk, so two stages before any use
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			linkSync_q <= 2'b00;
			act1_q <= 16'h0000;
			act2_q <= 16'h0000;
		end else begin
			linkSync_q <= {linkSync_q[0], linkUp};
			act1_q <= actualIn;
			act2_q <= act1_q;
		end
	end
	assign linkOk = linkSync_q[1];

	// ================================================================
	// millisecond time base
	// one-cycle tick every TICK_CYCLES clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_q <= 32'h0000_0000;
		end else if (msTick) begin
			tick_q <= 32'h0000_0000;
		end else begin
			tick_q <= tick_q + 32'h0000_0001;
		end
	end
	assign msTick = tick_q == 32'(TICK_CYCLES - 1);

	// ================================================================
	// address decode
	assign wrCtrl = busReq.wr && busReq.addr == OFM_CTRL_OFS;
	assign wrStatus = busReq.wr && busReq.addr == OFM_STATUS_OFS;
	assign delayHit = busReq.addr[7:6] == OFM_DELAY_OFS[7:6] && busReq.addr[1:0] == 2'b00;
	assign delayIdx = busReq.addr[5:2];

	// ================================================================
	// global configuration
	// alarm enable exists on every variant
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			report_q <= OFM_REPORT_RST;
		end else if (wrCtrl) begin
			report_q <= busReq.wdata[OFM_CTRL_REPORT_BIT];
		end
	end

	// prioritized boot is refused: the bit never sticks, a flag records the attempt
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prioRej_q <= 1'b0;
		end else if (wrCtrl && busReq.wdata[OFM_CTRL_PRIO_BIT]) begin
			prioRej_q <= 1'b1;
		end else if (wrStatus && busReq.wdata[OFM_STATUS_PRIOREJ_BIT]) begin
			prioRej_q <= 1'b0;
		end
	end

	// ================================================================
	// output targets and fail-safe configuration
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			target_q <= OFM_TARGET_RST;
		end else if (busReq.wr && busReq.addr == OFM_TARGET_OFS) begin
			target_q <= busReq.wdata[15:0];
		end
	end

	// policy codes only stored on output variants
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			failsafe_q <= OFM_FAILSAFE_RST;
		end else if (HAS_OUTPUTS && busReq.wr && busReq.addr == OFM_FAILSAFE_OFS) begin
			failsafe_q <= busReq.wdata;
		end
	end

	// last value commanded while the link was healthy
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			last_q <= OFM_TARGET_RST;
		end else if (linkOk) begin
			last_q <= target_q;
		end
	end

	// ================================================================
	// per-channel delay settings, one byte each
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < OFM_CHANNELS; i++) begin
				delay_q[i] <= OFM_DELAY_RST_MS;
			end
		end else if (HAS_OUTPUTS && busReq.wr && delayHit) begin
			delay_q[delayIdx] <= busReq.wdata[7:0];
		end
	end

	// ================================================================
	// per-channel command, monitoring and lock
	genvar g;
	generate
		for (g = 0; g < OFM_CHANNELS; g++) begin : gChan
			ofm_fs_t policy;
			logic fsVal;
			assign policy = ofm_fs_t'(failsafe_q[2*g +: 2]);

			// reserved code falls back to off, the safe choice
			always_comb begin
				case (policy)
					OFM_FS_ON: fsVal = 1'b1;
					OFM_FS_HOLD: fsVal = last_q[g];
					default: fsVal = 1'b0;
				endcase
			end
			assign cmd[g] = linkOk ? target_q[g] : fsVal;

			ofm_chan_mon uMon (
				.clk(clk),
				.rst(rst),
				.msTick(msTick),
				.cmdOn(drive_q[g]),
				.actualOn(act2_q[g]),
				.delayMs(delay_q[g]),
				.armed(armed[g]),
				.fault(fault[g])
			);

			// a short locks both slot channels when both are on
			assign lockSet[g] = shortEvt[g] | (shortEvt[g ^ 1] & drive_q[g] & drive_q[g ^ 1]);
		end
	endgenerate

	// ================================================================
	// error classification
	// driven on but reads off is a short and locks; fed-back voltage does not
	assign faultRise = fault & ~faultPrev_q;
	assign shortEvt = faultRise & drive_q & ~act2_q;
	assign errClr = (busReq.wr && busReq.addr == OFM_ERROR_OFS) ? busReq.wdata[15:0] : 16'h0000;
	assign unlock = (busReq.wr && busReq.addr == OFM_LOCK_OFS) ? busReq.wdata[15:0] : 16'h0000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			faultPrev_q <= 16'h0000;
		end else begin
			faultPrev_q <= fault;
		end
	end

	// sticky error flags, a new fault wins over a clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			error_q <= 16'h0000;
		end else begin
			error_q <= (error_q & ~errClr) | faultRise;
		end
	end

	// lock holds until the controller writes a one; a new lock wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_q <= 16'h0000;
		end else begin
			lock_q <= (lock_q & ~unlock) | lockSet;
		end
	end

	// ================================================================
	// output drive
	// a lock set this cycle already drops the output
	assign driveD = HAS_OUTPUTS ? (cmd & ~lock_q & ~lockSet) : 16'h0000;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drive_q <= 16'h0000;
		end else begin
			drive_q <= driveD;
		end
	end
	assign outDrive = drive_q;
	assign chanError = error_q;
	assign diagAlarm = report_q && error_q != 16'h0000;

	// ================================================================
	// read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_q <= 32'h0000_0000;
		end else if (!busReq.rd) begin
			rdData_q <= 32'h0000_0000;
		end else if (busReq.addr == OFM_CTRL_OFS) begin
			rdData_q <= {31'h0000_0000, report_q};
		end else if (busReq.addr == OFM_STATUS_OFS) begin
			rdData_q <= {30'h0000_0000, prioRej_q, linkOk};
		end else if (busReq.addr == OFM_TARGET_OFS) begin
			rdData_q <= {16'h0000, target_q};
		end else if (busReq.addr == OFM_FAILSAFE_OFS) begin
			rdData_q <= failsafe_q;
		end else if (busReq.addr == OFM_ERROR_OFS) begin
			rdData_q <= {16'h0000, error_q};
		end else if (busReq.addr == OFM_LOCK_OFS) begin
			rdData_q <= {16'h0000, lock_q};
		end else if (busReq.addr == OFM_DRIVE_OFS) begin
			rdData_q <= {armed, drive_q};
		end else if (delayHit) begin
			rdData_q <= {24'h00_0000, delay_q[delayIdx]};
		end else begin
			rdData_q <= 32'h0000_0000;
		end
	end
	assign rdData = rdData_q;

	// ================================================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence linkLost_s(int ch, logic [1:0] code);
		!linkOk && failsafe_q[2*ch +: 2] == code && !lock_q[ch] && !lockSet[ch];
	endsequence

	sequence shortSeen_s(int ch);
		shortEvt[ch] ##1 lock_q[ch];
	endsequence

	fs_off_a: assert property (linkLost_s(0, 2'h0) |=> !outDrive[0])
		else $error("fail-safe off not applied");
	fs_on_a: assert property (linkLost_s(1, 2'h1) |=> outDrive[1] == HAS_OUTPUTS)
		else $error("fail-safe on not applied");
	fs_hold_a: assert property (linkLost_s(2, 2'h2) |=> outDrive[2] == (HAS_OUTPUTS & $past(last_q[2])))
		else $error("fail-safe hold not applied");
	link_follow_a: assert property (linkOk && !lock_q[2] && !lockSet[2]
		|=> outDrive[2] == (HAS_OUTPUTS & $past(target_q[2])))
		else $error("target not followed");
	lock_off_a: assert property (shortSeen_s(0) |-> !outDrive[0] ##1 !outDrive[0])
		else $error("locked channel driven");
	lock_hold_a: assert property (lock_q[0] && !unlock[0] |=> lock_q[0])
		else $error("lock released without reset");
	err_sticky_a: assert property (faultRise[5] |=> chanError[5])
		else $error("fault not recorded");
	alarm_gate_a: assert property (!report_q |-> !diagAlarm)
		else $error("alarm while reporting disabled");
	prio_reject_a: assert property (wrCtrl && busReq.wdata[OFM_CTRL_PRIO_BIT] |=> prioRej_q ##1 1'b1)
		else $error("prioritized boot accepted");
	delay_store_a: assert property (HAS_OUTPUTS && busReq.wr && delayHit
		|=> delay_q[$past(delayIdx)] == $past(busReq.wdata[7:0]))
		else $error("delay setting not stored");
	blank_fault_a: assert property (!armed[6] |-> !fault[6])
		else $error("error reported during blanking");
	read_zero_a: assert property (!busReq.rd |=> rdData == 32'h0000_0000)
		else $error("read data outside read cycle");

	// reserved code, hold tracking, locks, clear paths, report store and the boot bit that must never stick
	fs_rsvd_a: assert property (linkLost_s(3, 2'h3) |=> !outDrive[3])
		else $error("reserved fail-safe code not off");
	hold_track_a: assert property (linkOk |=> last_q == $past(target_q))
		else $error("hold value not tracking target");
	lock_drive_a: assert property (lock_q[0] |-> !outDrive[0])
		else $error("locked channel driven on");
	slot_lock_a: assert property (shortEvt[0] && drive_q[1] |=> lock_q[1])
		else $error("slot partner not locked");
	unlock_clear_a: assert property (unlock[0] && lock_q[0] && !lockSet[0] |=> !lock_q[0])
		else $error("lock not released by reset write");
	feed_no_lock_a: assert property (faultRise[5] && !drive_q[5] && !lock_q[5] |=> !lock_q[5])
		else $error("fed-back voltage locked channel");
	err_clear_a: assert property (errClr[0] && !faultRise[0] |=> !chanError[0])
		else $error("error flag not cleared");
	report_store_a: assert property (wrCtrl |=> report_q == $past(busReq.wdata[OFM_CTRL_REPORT_BIT]))
		else $error("report enable not stored");
	prio_unread_a: assert property (busReq.rd && busReq.addr == OFM_CTRL_OFS |=> !rdData[OFM_CTRL_PRIO_BIT])
		else $error("boot request bit stuck");
endmodule
`default_nettype wire

// *** ofm_field_load.sv ***
`timescale 1ns/1ps
`default_nettype none
// ================================================================
// field load model: output pins read back through the load
module ofm_field_load (
	// clock
	input wire logic clk,
	// driven outputs and injected faults
	input wire logic [15:0] drive,
	input wire logic [15:0] shortMask,
	input wire logic [15:0] feedMask,
	// measured state
	output logic [15:0] actual
);
	// one-cycle lag stands in for load settling; a short pulls low, feedback pulls high
	always_ff @(posedge clk) begin
		actual <= (drive & ~shortMask) | feedMask;
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import ofm_pkg::*;
;
	// ================================================================
	// stimulus, design and load
	typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} ofm_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic linkUp = 1'b1;
	ofm_bus_req_t busReq = '0;
	logic [15:0] shortMask = 16'h0000;
	logic [15:0] feedMask = 16'h0000;
	logic [15:0] actualIn, outDrive, chanError, outIn;
	logic [31:0] rdData, rdIn, got;
	logic diagAlarm;
	int n_fail = 0;
	int comparisons = 0;
	int n;
	// register rows: address, write flag, write data, expected read
	ofm_row_t rows [18] = '{
		'{OFM_CTRL_OFS, 1'b0, 32'h0, 32'h1},
		'{OFM_STATUS_OFS, 1'b0, 32'h0, 32'h1},
		'{OFM_TARGET_OFS, 1'b0, 32'h0, 32'h0},
		'{OFM_FAILSAFE_OFS, 1'b0, 32'h0, 32'h0},
		'{OFM_DELAY_OFS, 1'b0, 32'h0, 32'h50},
		'{8'h7C, 1'b0, 32'h0, 32'h50},
		'{OFM_DRIVE_OFS, 1'b0, 32'h0, 32'h0},
		'{OFM_ERROR_OFS, 1'b0, 32'h0, 32'h0},
		'{OFM_LOCK_OFS, 1'b0, 32'h0, 32'h0},
		'{8'h20, 1'b0, 32'h0, 32'h0},
		'{OFM_CTRL_OFS, 1'b1, 32'h3, 32'h1},
		'{OFM_STATUS_OFS, 1'b0, 32'h0, 32'h3},
		'{OFM_STATUS_OFS, 1'b1, 32'h2, 32'h1},
		'{8'h7C, 1'b1, 32'hFF, 32'hFF},
		'{8'h7C, 1'b1, 32'h0, 32'h0},
		'{8'h20, 1'b1, 32'hFFFF, 32'h0},
		'{OFM_FAILSAFE_OFS, 1'b1, 32'hE4, 32'hE4},
		'{OFM_TARGET_OFS, 1'b1, 32'h5, 32'h5}
	};

	always #50 clk = ~clk;

	ofm_output_ctrl #(.TICK_CYCLES(10)) uut (.clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
		.linkUp(linkUp), .actualIn(actualIn), .outDrive(outDrive), .chanError(chanError), .diagAlarm(diagAlarm));
	// input-only variant on the same bus
	ofm_output_ctrl #(.TICK_CYCLES(10), .HAS_OUTPUTS(1'b0)) uutIn (.clk(clk), .rst(rst), .busReq(busReq),
		.rdData(rdIn), .linkUp(linkUp), .actualIn(16'h0000), .outDrive(outIn), .chanError(), .diagAlarm());
	ofm_field_load load (.clk(clk), .drive(outDrive), .shortMask(shortMask), .feedMask(feedMask),
		.actual(actualIn));

	// ================================================================
	// helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		busReq.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so sample it there
	task automatic br(input logic [7:0] a);
		@(posedge clk);
		busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		busReq.rd <= 1'b0;
		@(negedge clk);
		got = rdData;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask
	// bounded wait for a sticky error, cycles waited in n
	task automatic waitErr(input int ch, input int lim);
		n = 0;
		while (chanError[ch] !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				n_fail++;
				$display("mismatch at %0t ns: error flag never rose", $time);
				close_out();
			end
		end
	endtask

	// ================================================================
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({15'h0, diagAlarm, outDrive}, 32'h0);
		chk({16'h0, chanError}, 32'h0);
		foreach (rows[i]) begin
			if (rows[i].w) begin
				bw(rows[i].a, rows[i].d);
			end
			br(rows[i].a);
			chk(got, rows[i].e);
		end
		// link loss: off, on, hold, code 3 as off
		@(posedge clk);
		// link only drops once the controller's watchdog, longer than ring recovery, has run out
		linkUp <= 1'b0;
		cyc(5);
		chk({16'h0, outDrive}, 32'h6);
		chk({16'h0, outIn}, 32'h0);
		br(OFM_FAILSAFE_OFS);
		chk(rdIn, 32'h0);
		@(posedge clk);
		linkUp <= 1'b1;
		cyc(5);
		chk({16'h0, outDrive}, 32'h5);
		// per-channel blanking after edges, 10 ms against 80 ms
		cyc(900);
		bw(OFM_DELAY_OFS, 32'hA);
		bw(OFM_TARGET_OFS, 32'h0);
		bw(OFM_TARGET_OFS, 32'h3);
		cyc(300);
		br(OFM_DRIVE_OFS);
		chk(got, 32'hFFF9_0003);
		cyc(600);
		br(OFM_DRIVE_OFS);
		chk(got, 32'hFFFF_0003);
		// short on ch0 while both slot channels on
		@(posedge clk);
		shortMask <= 16'h0001;
		waitErr(0, 1300);
		chk(32'(n >= 990 && n <= 1040), 32'h1);
		cyc(2);
		chk({16'h0, outDrive}, 32'h0);
		chk({15'h0, diagAlarm, chanError}, 32'h1_0001);
		br(OFM_LOCK_OFS);
		chk(got, 32'h3);
		bw(OFM_CTRL_OFS, 32'h0);
		cyc(1);
		chk({31'h0, diagAlarm}, 32'h0);
		bw(OFM_CTRL_OFS, 32'h1);
		@(posedge clk);
		shortMask <= 16'h0000;
		cyc(20);
		chk({16'h0, outDrive}, 32'h0);
		bw(OFM_ERROR_OFS, 32'hFFFF);
		bw(OFM_LOCK_OFS, 32'h3);
		cyc(3);
		chk({outDrive, chanError}, 32'h0003_0000);
		// feedback on ch5 just after an edge: blanked 20 ms, then filtered, never locked
		bw(8'h54, 32'h14);
		bw(OFM_TARGET_OFS, 32'h23);
		bw(OFM_TARGET_OFS, 32'h3);
		@(posedge clk);
		feedMask <= 16'h0020;
		waitErr(5, 1600);
		chk(32'(n >= 1150 && n <= 1240), 32'h1);
		br(OFM_LOCK_OFS);
		chk(got, 32'h0);
		chk({16'h0, outDrive}, 32'h3);
		// mid-run reset drops outputs, errors and delay settings
		@(posedge clk);
		rst <= 1'b1;
		cyc(2);
		chk({outDrive, chanError}, 32'h0);
		@(posedge clk);
		rst <= 1'b0;
		br(OFM_DELAY_OFS);
		chk(got, 32'h50);
		br(OFM_DRIVE_OFS);
		chk(got, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
